// ===== core/pds_pkg.sv
package pds_pkg;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 5; // word index width
  localparam int DATA_W = 32; // register width
  localparam int NUM_PLL = 4; // synthesizer loops
  localparam int NUM_OUT = 6; // divided output banks
  localparam int NUM_SD = 12; // delta sample slots

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00; // source, mode, crystal
  localparam logic [4:0] REG_PLL0 = 5'h01; // four loop words follow
  localparam logic [4:0] REG_OUT1 = 5'h05; // six bank words follow
  localparam logic [4:0] REG_SPREAD = 5'h0B; // modulator setup
  localparam logic [4:0] REG_DELTA_LO = 5'h0C; // samples 0..7
  localparam logic [4:0] REG_DELTA_HI = 5'h0D; // samples 8..11
  localparam logic [4:0] REG_STATUS = 5'h0E; // live state
  localparam logic [4:0] REG_MULT01 = 5'h0F; // loops 0 and 1
  localparam logic [4:0] REG_MULT23 = 5'h10; // loops 2 and 3

  // ----------------------------------------
  // field layouts
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] frac_add; // first loop only
    logic [11:0] fb_count;
    logic [6:0] ref_div;
  } pds_pll_type;

  typedef struct packed {
    logic [1:0] dis_state; // level while stopped
    logic mode; // post divide mode
    logic [6:0] count;
  } pds_out_type;

  typedef struct packed {
    logic [5:0] offset;
    logic [2:0] quad_cnt;
    logic [3:0] step_per;
  } pds_ss_type;

  typedef struct packed {
    logic [1:0] drive; // oscillator drive strength
    logic [4:0] load_cap; // load capacitance code
    logic amp_double;
    logic dither_en;
    logic [1:0] switch_mode;
    logic prim_sel; // 1: alternate input is primary
  } pds_ctrl_type;

  typedef enum logic {SEL_PRIM, SEL_SEC} pds_sel_type;

  // ----------------------------------------
  // reset values and constants
  // ----------------------------------------
  localparam pds_ctrl_type CTRL_RST = '{2'b11, 5'h00, 1'b0, 1'b0, 2'b00, 1'b0};
  localparam pds_pll_type PLL_RST = '{4'h0, 12'h001, 7'h01};
  localparam pds_pll_type PLL3_RST = '{4'h0, 12'h00C, 7'h03};
  localparam pds_out_type OUT_RST = '{2'b10, 1'b0, 7'h7F};
  localparam pds_ss_type SS_RST = '{6'h00, 3'h0, 4'h0};
  localparam logic [6:0] DIV_ALL_ONES = 7'h7F; // stop or bypass code
  localparam logic [6:0] MIN_DIV_PLL3 = 7'h03; // lowest legal divide
  localparam logic [1:0] DIS_HIGH = 2'b01; // 00 low, 01 high, 1x float
  localparam logic [7:0] LOAD_BASE = 8'h1C; // 3.5 pF in 0.125 pF steps
  localparam logic [4:0] STEP_EXTRA = 5'h02; // cycles added per step
  localparam logic [1:0] MISS_EDGES = 2'h2; // secondary edges to switch
endpackage : pds_pkg

// ===== core/pds_clock_ctrl.sv
`timescale 1ns/100ps
// Overview of operation
// - zero ref divide stops loops 0-2; loop3 min 3
// - loop0 multiplier 2N+A+1, else 2N; others N
// - 7-bit ref divide, 12-bit feedback count per loop
// - source bit picks which input is primary
// - mode 0x: select pin picks primary or secondary
// - manual reference change causes no glitch
// - auto: switch after two silent secondary cycles
// - auto switchover reverts when primary returns
// - bank divide decode: stop, /1, /2, (Q+2)*2
// - stopped bank drives high, low or floats
// - undivided output has no divider or mode
// - load capacitance 3.5 pF plus code steps
// - modulator runs while step period nonzero
// - step length is step period plus two
// - quadrant holds twice count samples, mirrored
// - six-bit offset shifts centre for down spread
// - twelve four-bit delta samples, count-limited use
// - dither randomises lsb; double doubles amplitude
module pds_clock_ctrl (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [4:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [31:0] rd_data_o,
  input wire logic crystal_ref_input_i,
  input wire logic alt_clock_input_i,
  input wire logic input_clock_select_pin_i,
  input wire logic pfd_tick_i,
  output logic ref_clock_o,
  output logic ref_select_o,
  output logic [3:0] pll_power_down_o,
  output logic [3:0][6:0] pll_ref_div_o,
  output logic [3:0][13:0] pll_mult_o,
  output logic [5:0][8:0] out_divide_o,
  output logic [5:0] out_level_o,
  output logic [5:0] out_oe_n_o,
  output logic [7:0] load_cap_steps_o,
  output logic [1:0] osc_drive_o,
  output logic spread_active_o,
  output logic signed [8:0] frac_adjust_o
);
  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  pds_pkg::pds_ctrl_type ctrl_q; // global control
  pds_pkg::pds_pll_type [3:0] pll_q; // per loop dividers
  pds_pkg::pds_out_type [5:0] out_q; // per bank dividers
  pds_pkg::pds_ss_type ss_q; // modulator setup
  logic [11:0][3:0] sd_q; // delta samples

  // software writes, one word per strobe
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= pds_pkg::CTRL_RST;
      pll_q <= {pds_pkg::PLL3_RST, {3{pds_pkg::PLL_RST}}};
      out_q <= {6{pds_pkg::OUT_RST}};
      ss_q <= pds_pkg::SS_RST;
      sd_q <= '0;
    end else if (wr_en_i) begin
      // loop words at consecutive offsets
      for (int i = 0; i < pds_pkg::NUM_PLL; i++) begin
        if (addr_i == pds_pkg::REG_PLL0 + 5'(i)) begin
          pll_q[i] <= wr_data_i[22:0];
        end
      end
      // bank words; the undivided output has none
      for (int i = 0; i < pds_pkg::NUM_OUT; i++) begin
        if (addr_i == pds_pkg::REG_OUT1 + 5'(i)) begin
          out_q[i] <= wr_data_i[9:0];
        end
      end
      case (addr_i)
        pds_pkg::REG_CTRL: begin
          ctrl_q <= wr_data_i[11:0];
        end
        pds_pkg::REG_SPREAD: begin
          ss_q <= wr_data_i[12:0];
        end
        pds_pkg::REG_DELTA_LO: begin
          sd_q[7:0] <= wr_data_i;
        end
        pds_pkg::REG_DELTA_HI: begin
          sd_q[11:8] <= wr_data_i[15:0];
        end
        default: begin
          // unmapped or read-only: ignored
        end
      endcase
    end
  end

  // ----------------------------------------
  // loop divider decode
  // ----------------------------------------
  logic [1:0] cfg_fault_q; // bit0 A>N-1, bit1 loop3 divide low

  // multipliers and power state are registered copies
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pll_power_down_o <= '0;
      pll_ref_div_o <= '0;
      pll_mult_o <= '0;
      cfg_fault_q <= '0;
    end else begin
      for (int i = 0; i < pds_pkg::NUM_PLL; i++) begin
        pll_ref_div_o[i] <= pll_q[i].ref_div;
        pll_mult_o[i] <= {2'b00, pll_q[i].fb_count};
      end
      // loop0: doubled count plus optional fraction
      if (pll_q[0].frac_add != 4'h0) begin
        pll_mult_o[0] <= 14'({pll_q[0].fb_count, 1'b0})
          + 14'(pll_q[0].frac_add) + 14'h0001;
      end else begin
        pll_mult_o[0] <= 14'({pll_q[0].fb_count, 1'b0});
      end
      for (int i = 0; i < 3; i++) begin
        pll_power_down_o[i] <= (pll_q[i].ref_div == 7'h00);
      end
      // loop3 divides below three are unusable; hold it down
      pll_power_down_o[3] <= (pll_q[3].ref_div < pds_pkg::MIN_DIV_PLL3);
      cfg_fault_q[1] <= (pll_q[3].ref_div < pds_pkg::MIN_DIV_PLL3);
      cfg_fault_q[0] <= ({8'h00, pll_q[0].frac_add} >= pll_q[0].fb_count);
    end
  end

  // ----------------------------------------
  // output bank decode
  // ----------------------------------------
  // divide 0 marks a stopped bank; its divider stays powered
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_divide_o <= '0;
      out_level_o <= '0;
      out_oe_n_o <= '1;
    end else begin
      for (int i = 0; i < pds_pkg::NUM_OUT; i++) begin
        if (out_q[i].count == pds_pkg::DIV_ALL_ONES) begin
          out_divide_o[i] <= out_q[i].mode ? 9'h001 : 9'h000;
        end else if (!out_q[i].mode) begin
          out_divide_o[i] <= 9'h002;
        end else begin
          // (Q+2)*2 worked as 2Q+4 at nine bits so Q=126 gives 256
          out_divide_o[i] <= {1'b0, out_q[i].count, 1'b0} + 9'h004;
        end
        // stopped bank: hold level or release the pin
        if (out_q[i].count == pds_pkg::DIV_ALL_ONES && !out_q[i].mode) begin
          out_level_o[i] <= (out_q[i].dis_state == pds_pkg::DIS_HIGH);
          out_oe_n_o[i] <= out_q[i].dis_state[1];
        end else begin
          out_level_o[i] <= 1'b0;
          out_oe_n_o[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // crystal settings
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      load_cap_steps_o <= pds_pkg::LOAD_BASE;
      osc_drive_o <= pds_pkg::CTRL_RST.drive;
    end else begin
      load_cap_steps_o <= pds_pkg::LOAD_BASE + {3'b000, ctrl_q.load_cap};
      osc_drive_o <= ctrl_q.drive;
    end
  end

  // ----------------------------------------
  // reference selection
  // ----------------------------------------
  logic xtal_q, alt_q, xtal_p, alt_p; // samples and previous
  logic [1:0] miss_cnt_q; // secondary edges since primary moved
  pds_pkg::pds_sel_type sel_q; // wanted reference
  logic prim_now, prim_prev, sec_now, sec_prev, prim_move, sec_rise, auto_mode;

  // primary is the crystal input unless the source bit says otherwise
  always_comb begin
    prim_now = ctrl_q.prim_sel ? alt_q : xtal_q;
    prim_prev = ctrl_q.prim_sel ? alt_p : xtal_p;
    sec_now = ctrl_q.prim_sel ? xtal_q : alt_q;
    sec_prev = ctrl_q.prim_sel ? xtal_p : alt_p;
    prim_move = prim_now ^ prim_prev;
    sec_rise = sec_now & ~sec_prev;
    auto_mode = ctrl_q.switch_mode[1];
  end

  // input samples and their one-cycle history
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xtal_q <= 1'b0;
      alt_q <= 1'b0;
      xtal_p <= 1'b0;
      alt_p <= 1'b0;
    end else begin
      xtal_q <= crystal_ref_input_i;
      alt_q <= alt_clock_input_i;
      xtal_p <= xtal_q;
      alt_p <= alt_q;
    end
  end

  // activity watch; any primary edge clears the count
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      miss_cnt_q <= '0;
    end else if (prim_move) begin
      miss_cnt_q <= '0;
    end else if (sec_rise && miss_cnt_q != pds_pkg::MISS_EDGES) begin
      miss_cnt_q <= miss_cnt_q + 2'h1;
    end
  end

  // wanted reference: pin in manual, watch in automatic
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_q <= pds_pkg::SEL_PRIM;
    end else if (!auto_mode) begin
      sel_q <= input_clock_select_pin_i ? pds_pkg::SEL_SEC : pds_pkg::SEL_PRIM;
    end else begin
      case (sel_q)
        pds_pkg::SEL_PRIM: begin
          if (!prim_move && miss_cnt_q == pds_pkg::MISS_EDGES) begin
            sel_q <= pds_pkg::SEL_SEC;
          end
        end
        pds_pkg::SEL_SEC: begin
          if (prim_move) begin
            sel_q <= pds_pkg::SEL_PRIM;
          end
        end
        default: begin
          sel_q <= pds_pkg::SEL_PRIM;
        end
      endcase
    end
  end

  // swap only while both inputs are low, so no runt pulse escapes
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_select_o <= 1'b0;
      ref_clock_o <= 1'b0;
    end else begin
      if (!xtal_q && !alt_q) begin
        ref_select_o <= ctrl_q.prim_sel ^ (sel_q == pds_pkg::SEL_SEC);
      end
      ref_clock_o <= ref_select_o ? alt_q : xtal_q;
    end
  end

  // ----------------------------------------
  // spread modulator of loop 0
  // ----------------------------------------
  logic ss_on; // step period nonzero
  logic [4:0] tick_cnt_q; // detector cycles into this step
  logic [3:0] idx_q; // sample within quadrant
  logic [1:0] quad_q; // waveform quadrant
  logic signed [7:0] acc_q; // running delta sum
  logic [7:0] lfsr_q; // dither source
  logic step; // step boundary this cycle
  logic [3:0] n_samp, k; // samples per quadrant, slot used
  logic signed [7:0] delta;

  always_comb begin
    ss_on = (ss_q.step_per != 4'h0);
    step = ss_on && pfd_tick_i
      && (tick_cnt_q == {1'b0, ss_q.step_per} + pds_pkg::STEP_EXTRA - 5'h01);
    n_samp = {ss_q.quad_cnt, 1'b0};
    // odd quadrants walk the samples backwards
    k = quad_q[0] ? n_samp - 4'h1 - idx_q : idx_q;
    delta = (k < 4'(pds_pkg::NUM_SD)) ? 8'(sd_q[k]) : 8'sh00;
  end

  // step timing in detector cycles
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_q <= '0;
    end else if (!ss_on || step) begin
      tick_cnt_q <= '0;
    end else if (pfd_tick_i) begin
      tick_cnt_q <= tick_cnt_q + 5'h01;
    end
  end

  // walk samples; quadrants 0,3 rise and 1,2 fall
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idx_q <= '0;
      quad_q <= '0;
      acc_q <= '0;
    end else if (!ss_on) begin
      idx_q <= '0;
      quad_q <= '0;
      acc_q <= '0;
    end else if (step) begin
      acc_q <= (quad_q == 2'd1 || quad_q == 2'd2) ? acc_q - delta : acc_q + delta;
      if (idx_q + 4'h1 >= n_samp) begin
        idx_q <= '0;
        quad_q <= quad_q + 2'h1;
      end else begin
        idx_q <= idx_q + 4'h1;
      end
    end
  end

  // free-running dither sequence, moved once per step
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lfsr_q <= 8'h01;
    end else if (step) begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  // offset plus (doubled) sum, lsb dithered when asked
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frac_adjust_o <= '0;
      spread_active_o <= 1'b0;
    end else begin
      spread_active_o <= ss_on;
      if (!ss_on) begin
        frac_adjust_o <= '0;
      end else begin
        frac_adjust_o <= 9'(signed'({3'b000, ss_q.offset}))
          + (ctrl_q.amp_double ? 9'(acc_q) <<< 1 : 9'(acc_q))
          + 9'(ctrl_q.dither_en & lfsr_q[0]);
      end
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= '0;
    end else if (rd_en_i) begin
      rd_data_o <= '0; // unmapped reads zero
      for (int i = 0; i < pds_pkg::NUM_PLL; i++) begin
        if (addr_i == pds_pkg::REG_PLL0 + 5'(i)) begin
          rd_data_o <= {9'h000, pll_q[i]};
        end
      end
      for (int i = 0; i < pds_pkg::NUM_OUT; i++) begin
        if (addr_i == pds_pkg::REG_OUT1 + 5'(i)) begin
          rd_data_o <= {22'h000000, out_q[i]};
        end
      end
      case (addr_i)
        pds_pkg::REG_CTRL: rd_data_o <= {20'h00000, ctrl_q};
        pds_pkg::REG_SPREAD: rd_data_o <= {19'h00000, ss_q};
        pds_pkg::REG_DELTA_LO: rd_data_o <= sd_q[7:0];
        pds_pkg::REG_DELTA_HI: rd_data_o <= {16'h0000, sd_q[11:8]};
        pds_pkg::REG_STATUS: rd_data_o <= {14'h0000, 7'(frac_adjust_o[8:2]),
          frac_adjust_o[1:0], cfg_fault_q, spread_active_o, sel_q == pds_pkg::SEL_SEC,
          ref_select_o, pll_power_down_o};
        pds_pkg::REG_MULT01: rd_data_o <= {2'b00, pll_mult_o[1], 2'b00, pll_mult_o[0]};
        pds_pkg::REG_MULT23: rd_data_o <= {2'b00, pll_mult_o[3], 2'b00, pll_mult_o[2]};
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_loop_power_down: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    pll_q[1].ref_div == 7'h00 |=> pll_power_down_o[1]) else $error("loop1 not down");
  a_loop0_mult: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    pll_q[0].frac_add == 4'h0 |=> pll_mult_o[0] == {1'b0, $past(pll_q[0].fb_count), 1'b0})
    else $error("loop0 multiplier wrong");
  a_manual_pick: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !auto_mode |=> (sel_q == pds_pkg::SEL_SEC) == $past(input_clock_select_pin_i))
    else $error("manual pick wrong");
  a_swap_when_low: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $changed(ref_select_o) |-> $past(!xtal_q && !alt_q)) else $error("swap while high");
  a_auto_switch: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    auto_mode && sel_q == pds_pkg::SEL_PRIM && miss_cnt_q == 2'h2 && !prim_move
    |=> sel_q == pds_pkg::SEL_SEC) else $error("no switch to secondary");
  a_auto_revert: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    auto_mode && sel_q == pds_pkg::SEL_SEC && prim_move |=> sel_q == pds_pkg::SEL_PRIM)
    else $error("no revert to primary");
  a_bank_stop: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    out_q[0].count == 7'h7F && !out_q[0].mode |=> out_divide_o[0] == 9'h000)
    else $error("bank not stopped");
  a_load_cap: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    1'b1 |=> load_cap_steps_o == 8'd28 + $past(ctrl_q.load_cap)) else $error("load cap");
  a_spread_off: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    ss_q.step_per == 4'h0 |=> frac_adjust_o == 9'sh000 && !spread_active_o)
    else $error("modulator not off");
  a_step_length: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    step |-> tick_cnt_q == 5'(ss_q.step_per) + 5'd1) else $error("step length");
endmodule : pds_clock_ctrl

// ===== tb/pds_ref_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// redundant reference sources
// ----------------------------------------
module pds_ref_model (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic xtal_run_i,
  input wire logic alt_run_i,
  output logic xtal_o,
  output logic alt_o
);
  logic [1:0] xtal_cnt_q; // half period of two cycles
  logic [1:0] alt_cnt_q; // half period of three cycles

  // primary source; a stopped source falls to the pulled-down level
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xtal_cnt_q <= 2'h0;
      xtal_o <= 1'b0;
    end else if (!xtal_run_i) begin
      xtal_o <= 1'b0;
    end else begin
      xtal_cnt_q <= (xtal_cnt_q == 2'h1) ? 2'h0 : xtal_cnt_q + 2'h1;
      if (xtal_cnt_q == 2'h1) begin
        xtal_o <= ~xtal_o;
      end
    end
  end

  // secondary source, kept slower than the primary so auto mode is legal
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alt_cnt_q <= 2'h0;
      alt_o <= 1'b0;
    end else if (!alt_run_i) begin
      alt_o <= 1'b0;
    end else begin
      alt_cnt_q <= (alt_cnt_q == 2'h2) ? 2'h0 : alt_cnt_q + 2'h1;
      if (alt_cnt_q == 2'h2) begin
        alt_o <= ~alt_o;
      end
    end
  end
endmodule : pds_ref_model

// ===== tb/tb_pds_clock_ctrl.sv
`timescale 1ns/100ps
module tb_pds_clock_ctrl;
  // ----------------------------------------
  // stimulus table and signals
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] data;
    logic [2:0] kind; // which output to look at
    logic [2:0] idx;
    logic [15:0] exp;
  } pds_row_type;
  localparam pds_row_type ROWS [16] = '{
    '{5'h01, 32'h0018_0B01, 3'h0, 3'h0, 16'h0030},
    '{5'h01, 32'h0000_0C02, 3'h0, 3'h0, 16'h0030},
    '{5'h01, 32'h0000_0C02, 3'h1, 3'h0, 16'h0002},
    '{5'h01, 32'h0000_0B00, 3'h2, 3'h0, 16'h0001},
    '{5'h04, 32'h0000_0602, 3'h2, 3'h3, 16'h0001},
    '{5'h04, 32'h0007_FF83, 3'h2, 3'h3, 16'h0000},
    '{5'h04, 32'h0007_FF83, 3'h0, 3'h3, 16'h0FFF},
    '{5'h02, 32'h0000_327F, 3'h1, 3'h1, 16'h007F},
    '{5'h05, 32'h0000_007F, 3'h3, 3'h0, 16'h0000},
    '{5'h06, 32'h0000_00FF, 3'h3, 3'h1, 16'h0001},
    '{5'h07, 32'h0000_0005, 3'h3, 3'h2, 16'h0002},
    '{5'h08, 32'h0000_0085, 3'h3, 3'h3, 16'h000E},
    '{5'h09, 32'h0000_017F, 3'h4, 3'h4, 16'h0001},
    '{5'h0A, 32'h0000_027F, 3'h5, 3'h5, 16'h0001},
    '{5'h00, 32'h0000_0FE0, 3'h6, 3'h0, 16'h003B},
    '{5'h0B, 32'h0000_1A2E, 3'h7, 3'h0, 16'h0001}
  };
  // expected waveform for two samples of 3 and 2
  localparam int EXPV [8] = '{3, 5, 3, 0, -3, -5, -3, 0};
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [4:0] addr_i = 5'h00;
  logic [31:0] wr_data_i = 32'h0;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [31:0] rd_data_o;
  logic crystal_ref_input_i;
  logic alt_clock_input_i;
  logic input_clock_select_pin_i = 1'b0;
  logic pfd_tick_i = 1'b0;
  logic xtal_run = 1'b1; // primary source running
  logic ref_clock_o;
  logic ref_select_o;
  logic [3:0] pll_power_down_o;
  logic [3:0][6:0] pll_ref_div_o;
  logic [3:0][13:0] pll_mult_o;
  logic [5:0][8:0] out_divide_o;
  logic [5:0] out_level_o;
  logic [5:0] out_oe_n_o;
  logic [7:0] load_cap_steps_o;
  logic [1:0] osc_drive_o;
  logic spread_active_o;
  logic signed [8:0] frac_adjust_o;
  logic [31:0] got;
  int n_errors = 0;
  int checks = 0;

  pds_clock_ctrl u_pds_clock_ctrl (.clock_i, .reset_n_i, .addr_i, .wr_data_i, .wr_en_i,
    .rd_en_i, .rd_data_o, .crystal_ref_input_i, .alt_clock_input_i,
    .input_clock_select_pin_i, .pfd_tick_i, .ref_clock_o, .ref_select_o, .pll_power_down_o,
    .pll_ref_div_o, .pll_mult_o, .out_divide_o, .out_level_o, .out_oe_n_o,
    .load_cap_steps_o, .osc_drive_o, .spread_active_o, .frac_adjust_o);
  pds_ref_model u_pds_ref_model (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .xtal_run_i(xtal_run), .alt_run_i(1'b1), .xtal_o(crystal_ref_input_i),
    .alt_o(alt_clock_input_i));

  // ----------------------------------------
  // clock, phase detector ticks, helpers
  // ----------------------------------------
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  // one tick every other cycle
  always @(posedge clock_i) begin
    pfd_tick_i <= ~pfd_tick_i;
  end
  function automatic logic [15:0] pick(input logic [2:0] k, input logic [2:0] i);
    case (k)
      3'h0: pick = {2'h0, pll_mult_o[i[1:0]]};
      3'h1: pick = {9'h0, pll_ref_div_o[i[1:0]]};
      3'h2: pick = {15'h0, pll_power_down_o[i[1:0]]};
      3'h3: pick = {7'h0, out_divide_o[i]};
      3'h4: pick = {15'h0, out_level_o[i]};
      3'h5: pick = {15'h0, out_oe_n_o[i]};
      3'h6: pick = {8'h0, load_cap_steps_o};
      default: pick = {15'h0, spread_active_o};
    endcase
  endfunction : pick
  task automatic wrap_up;
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t got %0h expected %0h", $time, g, e);
    end
  endtask : chk
  // write edge is the second edge of the task
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge clock_i);
    wr_en_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge clock_i);
    rd_en_i <= 1'b0;
    #1 d = rd_data_o;
  endtask : rd
  // derived outputs land one edge after the write edge
  task automatic settle;
    repeat (2) @(posedge clock_i);
    #1;
  endtask : settle
  // bounded wait for the reference selection
  task automatic wait_sel(input logic v);
    int k;
    k = 0;
    while (ref_select_o !== v && k < 80) begin
      @(posedge clock_i);
      #1;
      k++;
    end
    chk({31'h0, ref_select_o}, {31'h0, v});
    if (k == 80) wrap_up;
  endtask : wait_sel
  // runs one modulation period and checks every step value
  task automatic mod_run(input int scale);
    logic signed [8:0] prev;
    int n;
    int t0;
    wr(pds_pkg::REG_SPREAD, 32'h0);
    settle;
    wr(pds_pkg::REG_DELTA_LO, 32'h0000_0F23);
    wr(pds_pkg::REG_SPREAD, 32'h0000_0015);
    prev = '0;
    n = 0;
    t0 = 0;
    for (int k = 0; k < 400 && n < 8; k++) begin
      @(posedge clock_i);
      #1;
      if (frac_adjust_o !== prev) begin
        chk({23'h0, frac_adjust_o}, {23'h0, 9'(EXPV[n] * scale)});
        if (n == 2) chk(32'(k - t0), 32'h0000_000E);
        t0 = k;
        prev = frac_adjust_o;
        n++;
      end
    end
    chk(32'(n), 32'h0000_0008);
    if (n < 8) wrap_up;
    wr(pds_pkg::REG_SPREAD, 32'h0);
    settle;
    chk({23'h0, frac_adjust_o}, 32'h0);
    chk({31'h0, spread_active_o}, 32'h0);
  endtask : mod_run

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clock_i);
    #1;
    chk({26'h0, out_oe_n_o}, 32'h0000_003F);
    chk({24'h0, load_cap_steps_o}, 32'h0000_001C);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    chk({18'h0, pll_mult_o[3]}, 32'h0000_000C);
    chk({18'h0, pll_mult_o[0]}, 32'h0000_0002);
    rd(pds_pkg::REG_CTRL, got);
    chk(got, 32'h0000_0C00);
    rd(5'h11, got);
    chk(got, 32'h0);
    for (int r = 0; r < 16; r++) begin
      wr(ROWS[r].addr, ROWS[r].data);
      settle;
      chk({16'h0, pick(ROWS[r].kind, ROWS[r].idx)}, {16'h0, ROWS[r].exp});
    end
    // last row left offset 0x34 with no step taken yet
    chk({23'h0, frac_adjust_o}, 32'h0000_0034);
    wr(pds_pkg::REG_OUT1, 32'h0000_00FE);
    settle;
    chk({23'h0, out_divide_o[0]}, 32'h0000_0100);
    // manual mode, crystal primary then alternate primary
    wr(pds_pkg::REG_CTRL, 32'h0000_0C00);
    input_clock_select_pin_i <= 1'b1;
    wait_sel(1'b1);
    @(posedge clock_i);
    input_clock_select_pin_i <= 1'b0;
    wait_sel(1'b0);
    wr(pds_pkg::REG_CTRL, 32'h0000_0C01);
    wait_sel(1'b1);
    // automatic mode with crystal primary and default crystal setup
    wr(pds_pkg::REG_CTRL, 32'h0000_0C04);
    repeat (30) @(posedge clock_i);
    #1;
    chk({31'h0, ref_select_o}, 32'h0);
    @(posedge clock_i);
    xtal_run <= 1'b0;
    wait_sel(1'b1);
    @(posedge clock_i);
    xtal_run <= 1'b1;
    wait_sel(1'b0);
    // modulator at nominal and doubled amplitude
    mod_run(1);
    wr(pds_pkg::REG_CTRL, 32'h0000_0C10);
    mod_run(2);
    wrap_up;
  end
endmodule : tb_pds_clock_ctrl
